//--- pkg/i2cbf_pkg.sv
// Shared constants and types for the two-wire bus framing block.
// How it works
// - Bytes shift whole, most significant bit first.
// - Each unit: eight data bits plus acknowledge.
// - Sender releases data after eighth fall.
// - Only the master drives clock pulses.
// - Data changes while clock low; sampled rising.
// - Enabled port drives both pins open-drain.
// - Hold select picks 300 ns data hold.
// - Start: data falls while clock high.
// - Stop: data rises while clock high.
// - Stop needs one clock low after Start.
// - Restart allowed wherever Stop is valid.
// - Restart resets slave exactly like Start.
// - Ten-bit read: full match, Restart, read.
// - Idle: no master, both lines high.
// - Released data sampled low flags collision.
// - Address equal to slave address matches.
// - Matched address with write bit receives.
// - Read request: slave sends until the master NACKs.
// - Anyone may hold clock low; master waits.
// - Ninth pulse: receiver pulls data low.
package i2cbf_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int         CLK_NS         = 100;
	localparam int         HOLD_SHORT_NS  = 100;
	localparam int         HOLD_LONG_NS   = 300;
	localparam logic [1:0] HOLD_SHORT_CYC = 2'((HOLD_SHORT_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [1:0] HOLD_LONG_CYC  = 2'((HOLD_LONG_NS + CLK_NS - 1) / CLK_NS);
	localparam int         SCL_HALF_NS    = 400;
	localparam logic [7:0] SCL_HALF_CYC   = 8'(SCL_HALF_NS / CLK_NS);

	// ----------------------------------------
	// Framing
	// ----------------------------------------
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	localparam logic [4:0] ADDR10_HDR = 5'h1E;
	localparam int         DATA_W     = 8;
	localparam int         FIFO_DEPTH = 4;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		S_IDLE    = 3'h0,
		S_RX      = 3'h1,
		S_ACK_OUT = 3'h3,
		S_TX      = 3'h2,
		S_ACK_IN  = 3'h6,
		S_WAIT    = 3'h7
	} i2cbf_sst_e;

	typedef enum logic [1:0] {
		K_HI   = 2'h0,
		K_LO   = 2'h1,
		K_DATA = 2'h2
	} i2cbf_kind_e;

	typedef enum logic [2:0] {
		M_IDLE = 3'h0,
		M_LOW  = 3'h1,
		M_HIGH = 3'h3,
		M_COND = 3'h2,
		M_DONE = 3'h6
	} i2cbf_mst_e;

	typedef enum logic [1:0] {
		C_START = 2'h0,
		C_STOP  = 2'h1,
		C_WRITE = 2'h2,
		C_READ  = 2'h3
	} i2cbf_cmd_e;

endpackage

//--- pkg/i2cbf_if.sv
// Two-wire bus carrier joining the device end and the host end.
`timescale 1ns/10ps
interface i2cbf_if;
	logic dev_scl_o;
	logic dev_scl_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND with pull-ups: a line is low while any enabled driver pulls low.
	assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
	assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

	modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

//--- design/i2cbf_dev.sv
// Slave end of the two-wire bus with its receive FIFO.
`timescale 1ns/10ps

// ----------------------------------------
// Receive FIFO
// ----------------------------------------
module i2cbf_fifo #(
	parameter int W  = 8,
	parameter int D  = 4,
	parameter int AW = 2
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         sys_rst,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0]         wp;
		logic [AW:0]         rp;
	} i2cbf_fifo_s;

	i2cbf_fifo_s r, n;

	// Pointers carry one extra bit so full and empty stay distinct.
	assign in_ready  = (r.wp - r.rp) != (AW + 1)'(D);
	assign out_valid = r.wp != r.rp;
	assign out_data  = r.mem[r.rp[AW-1:0]];

	// Write on accepted push, advance read on accepted pop.
	always_comb begin
		n = r;
		if (in_valid && in_ready) begin
			n.mem[r.wp[AW-1:0]] = in_data;
			n.wp = r.wp + 1'b1;
		end
		if (out_valid && out_ready) begin
			n.rp = r.rp + 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule

// ----------------------------------------
// Device end
// ----------------------------------------
module i2cbf_dev
	import i2cbf_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              sys_rst,
	// Bus
	i2cbf_if.dev                   bus,
	// Control
	input  wire logic              port_module_enable,
	input  wire logic              data_hold_select,
	input  wire logic              addr_ten_bit,
	input  wire logic [9:0]        slave_address_reg,
	// Received bytes
	output logic                   rx_valid,
	input  wire logic              rx_ready,
	output logic [DATA_W-1:0]      rx_data,
	// Bytes to send
	input  wire logic              tx_valid,
	input  wire logic [DATA_W-1:0] tx_data,
	output logic                   tx_take,
	// Status
	output logic                   bus_idle,
	output logic                   start_seen,
	output logic                   stop_seen,
	output logic                   collision
);
	typedef struct packed {
		logic [1:0]  scl_m;
		logic [1:0]  sda_m;
		logic        scl_d;
		logic        sda_d;
		i2cbf_sst_e  st;
		i2cbf_kind_e kind;
		logic [3:0]  bitc;
		logic [7:0]  sh;
		logic        rw;
		logic        ten_ok;
		logic        low_seen;
		logic        busy;
		logic        idle;
		logic        want;
		logic        sda_oe;
		logic        scl_oe;
		logic        rx_v;
		logic        ld;
		logic        acked;
		logic [1:0]  hcnt;
		logic        start_p;
		logic        stop_p;
		logic        coll_p;
		logic        take_p;
	} i2cbf_dev_s;

	i2cbf_dev_s r, n;
	logic       fifo_in_ready;
	logic       scl;
	logic       sda;
	logic       rise;
	logic       fall;
	logic [1:0] hold;

	// High and low address bytes each check against their own part.
	function automatic logic addr_hit(input logic [7:0] b, input i2cbf_kind_e k, input logic ten,
		input logic [9:0] a, input logic tok);
		logic hit;
		hit = 1'b1;
		unique case (k)
			K_HI: begin
				if (ten) begin
					hit = (b[7:3] == ADDR10_HDR) && (b[2:1] == a[9:8]) && (!b[0] || tok);
				end else begin
					hit = b[7:1] == a[6:0];
				end
			end
			K_LO: hit = b == a[7:0];
			default: hit = 1'b1;
		endcase
		return hit;
	endfunction

	// Only the second synchroniser stage and the delayed copy are looked at.
	assign scl  = r.scl_m[1];
	assign sda  = r.sda_m[1];
	assign rise = scl & ~r.scl_d;
	assign fall = ~scl & r.scl_d;
	assign hold = data_hold_select ? HOLD_LONG_CYC : HOLD_SHORT_CYC;

	// Pins only ever pull low; the output value is fixed at zero.
	assign bus.dev_scl_o  = 1'b0;
	assign bus.dev_sda_o  = 1'b0;
	assign bus.dev_scl_oe = r.scl_oe;
	assign bus.dev_sda_oe = r.sda_oe;
	assign tx_take        = r.take_p;
	assign bus_idle       = r.idle;
	assign start_seen     = r.start_p;
	assign stop_seen      = r.stop_p;
	assign collision      = r.coll_p;

	// Received bytes wait here; a full FIFO stretches the clock.
	i2cbf_fifo #(.W(DATA_W), .D(DEPTH), .AW($clog2(DEPTH))) u_rx_fifo (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.in_valid  (r.rx_v),
		.in_ready  (fifo_in_ready),
		.in_data   (r.sh),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);

	// Bus tracking, condition detection and byte sequencing.
	always_comb begin
		n         = r;
		n.scl_m   = {r.scl_m[0], bus.scl};
		n.sda_m   = {r.sda_m[0], bus.sda};
		n.scl_d   = scl;
		n.sda_d   = sda;
		n.start_p = 1'b0;
		n.stop_p  = 1'b0;
		n.coll_p  = 1'b0;
		n.take_p  = 1'b0;
		// Data only moves once the selected hold has elapsed after the fall.
		if (r.hcnt != 2'h0) begin
			n.hcnt = r.hcnt - 2'h1;
		end else begin
			n.sda_oe = r.want;
		end
		if (!scl) begin
			n.low_seen = 1'b1;
		end
		if (scl && r.scl_d && r.sda_d && !sda) begin
			// Start or Restart: the slave logic starts over either way.
			n.busy     = 1'b1;
			n.low_seen = 1'b0;
			n.st       = S_RX;
			n.kind     = K_HI;
			n.bitc     = 4'h0;
			n.want     = 1'b0;
			n.sda_oe   = 1'b0;
			n.hcnt     = 2'h0;
			n.scl_oe   = 1'b0;
			n.rx_v     = 1'b0;
			n.rw       = 1'b0;
			n.start_p  = 1'b1;
		end else if (scl && r.scl_d && !r.sda_d && sda && r.low_seen) begin
			n.busy     = 1'b0;
			n.low_seen = 1'b0;
			n.st       = S_IDLE;
			n.ten_ok   = 1'b0;
			n.want     = 1'b0;
			n.sda_oe   = 1'b0;
			n.hcnt     = 2'h0;
			n.scl_oe   = 1'b0;
			n.rx_v     = 1'b0;
			n.rw       = 1'b0;
			n.stop_p   = 1'b1;
		end else begin
			unique case (r.st)
				S_IDLE, S_WAIT: begin
				end
				S_RX: begin
					if (rise) begin
						n.sh   = {r.sh[6:0], sda};
						n.bitc = r.bitc + 4'h1;
					end else if (fall && r.bitc == BYTE_BITS) begin
						// Eighth fall: judge the byte; only a match holds the clock.
						if (addr_hit(r.sh, r.kind, addr_ten_bit, slave_address_reg, r.ten_ok)) begin
							n.st     = S_ACK_OUT;
							n.scl_oe = 1'b1;
							n.hcnt   = hold;
							n.rx_v   = r.kind == K_DATA;
							if (r.kind == K_HI) begin
								n.rw = r.sh[0];
							end
							if (r.kind == K_LO) begin
								n.ten_ok = 1'b1;
							end
						end else begin
							n.st = S_WAIT;
						end
					end
				end
				S_ACK_OUT: begin
					if (r.scl_oe) begin
						if (!r.rx_v || fifo_in_ready) begin
							n.rx_v = 1'b0;
							n.want = 1'b1;
							if (r.hcnt == 2'h0 && r.sda_oe) begin
								n.scl_oe = 1'b0;
							end
						end
					end else if (fall) begin
						// Ninth fall ends the acknowledge pulse.
						n.want = 1'b0;
						n.hcnt = hold;
						n.bitc = 4'h0;
						if (r.rw) begin
							n.st     = S_TX;
							n.scl_oe = 1'b1;
							n.ld     = 1'b0;
						end else begin
							n.st   = S_RX;
							n.kind = (r.kind == K_HI && addr_ten_bit) ? K_LO : K_DATA;
						end
					end
				end
				S_TX: begin
					if (r.scl_oe) begin
						// Clock stays low until the user has a byte ready.
						if (!r.ld) begin
							if (tx_valid) begin
								n.sh     = tx_data;
								n.want   = ~tx_data[7];
								n.ld     = 1'b1;
								n.take_p = 1'b1;
							end
						end else if (r.hcnt == 2'h0 && r.sda_oe == r.want) begin
							n.scl_oe = 1'b0;
						end
					end else if (rise) begin
						n.bitc = r.bitc + 4'h1;
						if (!r.sda_oe && !sda) begin
							n.coll_p = 1'b1;
							n.st     = S_WAIT;
							n.want   = 1'b0;
							n.sda_oe = 1'b0;
							n.hcnt   = 2'h0;
						end
					end else if (fall) begin
						n.hcnt = hold;
						if (r.bitc == BYTE_BITS) begin
							n.want = 1'b0;
							n.st   = S_ACK_IN;
						end else begin
							n.sh   = {r.sh[6:0], 1'b0};
							n.want = ~r.sh[6];
						end
					end
				end
				S_ACK_IN: begin
					if (rise) begin
						n.acked = ~sda;
					end else if (fall) begin
						if (r.acked) begin
							n.st     = S_TX;
							n.scl_oe = 1'b1;
							n.ld     = 1'b0;
							n.bitc   = 4'h0;
						end else begin
							n.st = S_WAIT;
						end
					end
				end
				default: n.st = S_IDLE;
			endcase
		end
		n.idle = ~n.busy & scl & sda;
		// A disabled port lets go of both pins and forgets the transfer.
		if (!port_module_enable) begin
			n = '0;
		end
	end

	// State register.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule

//--- design/i2cbf_host.sv
// Master end of the two-wire bus, driven by byte-level commands.
`timescale 1ns/10ps
module i2cbf_host
	import i2cbf_pkg::*;
#(
	parameter logic [7:0] HALF = SCL_HALF_CYC
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              sys_rst,
	// Bus
	i2cbf_if.host                  bus,
	// Commands
	input  wire logic              cmd_valid,
	input  wire i2cbf_cmd_e        cmd,
	input  wire logic [DATA_W-1:0] cmd_data,
	input  wire logic              cmd_nack,
	output logic                   cmd_ready,
	// Responses
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_data,
	output logic                   rsp_ack,
	output logic                   rsp_lost
);
	typedef struct packed {
		logic [1:0] scl_m;
		logic [1:0] sda_m;
		i2cbf_mst_e st;
		i2cbf_cmd_e op;
		logic [7:0] sh;
		logic [3:0] nb;
		logic [7:0] cnt;
		logic       nack;
		logic       scl_oe;
		logic       sda_oe;
		logic       owned;
		logic       got;
		logic       smp;
		logic       ackr;
		logic       lost;
		logic       rdy;
		logic       rsp_v;
	} i2cbf_host_s;

	i2cbf_host_s r, n;
	logic        scl;
	logic        sda;
	logic        drv;

	assign scl             = r.scl_m[1];
	assign sda             = r.sda_m[1];
	assign bus.host_scl_o  = 1'b0;
	assign bus.host_sda_o  = 1'b0;
	assign bus.host_scl_oe = r.scl_oe;
	assign bus.host_sda_oe = r.sda_oe;
	assign cmd_ready       = r.rdy;
	assign rsp_valid       = r.rsp_v;
	assign rsp_data        = r.sh;
	assign rsp_ack         = r.ackr;
	assign rsp_lost        = r.lost;

	// Whether this bit pulls data low during the clock-low half.
	always_comb begin
		unique case (r.op)
			C_START: drv = 1'b0;
			C_STOP:  drv = 1'b1;
			C_WRITE: drv = (r.nb < BYTE_BITS) ? ~r.sh[7] : 1'b0;
			C_READ:  drv = (r.nb < BYTE_BITS) ? 1'b0 : ~r.nack;
		endcase
	end

	// Clock generation by divider and per-bit sequencing.
	always_comb begin
		n       = r;
		n.scl_m = {r.scl_m[0], bus.scl};
		n.sda_m = {r.sda_m[0], bus.sda};
		n.rsp_v = 1'b0;
		if (r.cnt != 8'h0) begin
			n.cnt = r.cnt - 8'h1;
		end
		unique case (r.st)
			M_IDLE: begin
				// Ready rises on its own once reset is over; taking a command lowers it again.
				n.rdy = 1'b1;
				// A fresh Start waits for an idle bus; a Restart needs no wait.
				if (r.rdy && cmd_valid && (cmd != C_START || r.owned || (scl && sda))) begin
					n.rdy  = 1'b0;
					n.op   = cmd;
					n.sh   = cmd_data;
					n.nack = cmd_nack;
					n.nb   = 4'h0;
					n.lost = 1'b0;
					n.cnt  = HALF;
					if (cmd == C_START && !r.owned) begin
						n.sda_oe = 1'b1;
						n.st     = M_COND;
					end else begin
						n.scl_oe = 1'b1;
						n.st     = M_LOW;
					end
				end
			end
			M_LOW: begin
				if (r.cnt == (HALF >> 1)) begin
					n.sda_oe = drv;
				end
				if (r.cnt == 8'h0) begin
					n.scl_oe = 1'b0;
					n.st     = M_HIGH;
					n.cnt    = HALF;
					n.got    = 1'b0;
				end
			end
			M_HIGH: begin
				if (!scl) begin
					n.cnt = HALF;
				end else if (!r.got) begin
					n.got = 1'b1;
					n.smp = sda;
					if (r.op == C_WRITE && r.nb < BYTE_BITS && !r.sda_oe && !sda) begin
						// Lost arbitration: let go of both lines at once.
						n.lost   = 1'b1;
						n.owned  = 1'b0;
						n.scl_oe = 1'b0;
						n.sda_oe = 1'b0;
						n.st     = M_DONE;
					end
				end else if (r.cnt == 8'h0) begin
					n.cnt = HALF;
					if (r.op == C_START) begin
						n.sda_oe = 1'b1;
						n.st     = M_COND;
					end else if (r.op == C_STOP) begin
						n.sda_oe = 1'b0;
						n.st     = M_COND;
					end else if (r.nb == BYTE_BITS) begin
						n.ackr   = ~r.smp;
						n.scl_oe = 1'b1;
						n.st     = M_DONE;
					end else begin
						n.sh     = {r.sh[6:0], r.smp};
						n.nb     = r.nb + 4'h1;
						n.scl_oe = 1'b1;
						n.st     = M_LOW;
					end
				end
			end
			M_COND: begin
				if (r.cnt == 8'h0) begin
					n.owned  = r.op == C_START;
					n.scl_oe = r.op == C_START;
					n.st     = M_DONE;
				end
			end
			M_DONE: begin
				n.rsp_v = 1'b1;
				n.rdy   = 1'b1;
				n.st    = M_IDLE;
			end
			default: n.st = M_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule

//--- testbench/i2cbf_sva.sv
// Concurrent checks on the shared two-wire bus between the two ends.
`timescale 1ns/10ps
module i2cbf_sva (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Resolved lines and drivers
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_scl_o,
	input wire logic dev_scl_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic host_scl_o,
	input wire logic host_sda_o,
	// Device control and status
	input wire logic data_hold_select,
	input wire logic bus_idle,
	input wire logic start_seen,
	input wire logic stop_seen
);
	logic [3:0] low_cnt_r;
	logic [3:0] fall_age_r;
	logic [3:0] rise_age_r;
	logic       low_seen_r;

	// Ages since line events; they saturate so a stale event never looks fresh.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			low_cnt_r  <= 4'hF;
			fall_age_r <= 4'hF;
			rise_age_r <= 4'hF;
			low_seen_r <= 1'b1;
		end else begin
			low_cnt_r  <= scl ? 4'h0 : (low_cnt_r == 4'hF ? 4'hF : low_cnt_r + 4'h1);
			fall_age_r <= ($fell(sda) && scl && $past(scl)) ? 4'h0 : (fall_age_r == 4'hF ? 4'hF : fall_age_r + 4'h1);
			rise_age_r <= ($rose(sda) && scl && $past(scl)) ? 4'h0 : (rise_age_r == 4'hF ? 4'hF : rise_age_r + 4'h1);
			low_seen_r <= ($fell(sda) && scl && $past(scl)) ? 1'b0 : (low_seen_r | ~scl);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	AST_DEV_OPEN_DRAIN: assert property (!dev_scl_o && !dev_sda_o)
		else $error("device end drives a line high");
	AST_HOST_OPEN_DRAIN: assert property (!host_scl_o && !host_sda_o)
		else $error("host end drives a line high");
	AST_DEV_NO_CLOCK: assert property ($rose(dev_scl_oe) |-> !$past(scl))
		else $error("device pulled the clock low while it was high");
	AST_DEV_SDA_HOLD: assert property ($changed(dev_sda_oe) |-> !scl && low_cnt_r >= (data_hold_select ? 4'h3 : 4'h1))
		else $error("device changed data outside the clock low hold window");
	AST_START_LAG: assert property (start_seen |-> fall_age_r inside {[1:8]})
		else $error("start flagged without a recent data fall under high clock");
	AST_START_BUSY: assert property (start_seen |=> !bus_idle)
		else $error("bus idle right after a start");
	AST_STOP_LAG: assert property (stop_seen |-> rise_age_r inside {[1:8]})
		else $error("stop flagged without a recent data rise under high clock");
	AST_STOP_NEEDS_LOW: assert property (stop_seen |-> low_seen_r)
		else $error("stop flagged with no clock low since the start");
	AST_IDLE_LINES: assert property ((!scl || !sda) [*5] |-> !bus_idle)
		else $error("bus idle while a line is held low");
endmodule

//--- testbench/i2c_bus_framing_conditions_tb.sv
// Self-checking bench: host end commands transfers to the device end.
`timescale 1ns/10ps
module i2c_bus_framing_conditions_tb import i2cbf_pkg::*;;
	logic              clock = 1'b0;
	logic              sys_rst = 1'b1;
	logic              port_module_enable = 1'b1;
	logic              data_hold_select = 1'b0;
	logic              addr_ten_bit = 1'b0;
	logic [9:0]        slave_address_reg = 10'h05A;
	logic              rx_ready = 1'b1;
	logic              tx_valid = 1'b1;
	logic              cmd_valid = 1'b0;
	logic              cmd_nack = 1'b0;
	logic [DATA_W-1:0] cmd_data = 8'h00;
	i2cbf_cmd_e        cmd = C_START;
	logic [DATA_W-1:0] rx_data, tx_data, rsp_data;
	logic              rx_valid, tx_take, bus_idle, start_seen, stop_seen, collision;
	logic              cmd_ready, rsp_valid, rsp_ack, rsp_lost;
	logic              scl_q = 1'b1;
	logic [8:0]        wire_bits = 9'h000;
	logic [3:0]        tx_idx = 4'h1;
	logic [7:0]        wdat [5] = '{8'hA5, 8'h3C, 8'h81, 8'h7E, 8'h01};
	logic [7:0]        got [$];
	logic [7:0]        sent [$];
	int                n_mismatch = 0, tests_run = 0, n_start = 0, n_stop = 0, n_coll = 0;

	i2cbf_if bus ();
	i2cbf_dev #(.DEPTH(4)) i2cbf_dev_inst (.clock(clock), .sys_rst(sys_rst), .bus(bus.dev),
		.port_module_enable(port_module_enable), .data_hold_select(data_hold_select), .addr_ten_bit(addr_ten_bit),
		.slave_address_reg(slave_address_reg), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take), .bus_idle(bus_idle),
		.start_seen(start_seen), .stop_seen(stop_seen), .collision(collision));
	i2cbf_host #(.HALF(8'h08)) i2cbf_host_inst (.clock(clock), .sys_rst(sys_rst), .bus(bus.host),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_data(cmd_data), .cmd_nack(cmd_nack), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack), .rsp_lost(rsp_lost));
	i2cbf_sva i2cbf_sva_inst (.clock(clock), .sys_rst(sys_rst), .scl(bus.scl), .sda(bus.sda),
		.dev_scl_o(bus.dev_scl_o), .dev_scl_oe(bus.dev_scl_oe), .dev_sda_o(bus.dev_sda_o),
		.dev_sda_oe(bus.dev_sda_oe), .host_scl_o(bus.host_scl_o), .host_sda_o(bus.host_sda_o),
		.data_hold_select(data_hold_select), .bus_idle(bus_idle), .start_seen(start_seen), .stop_seen(stop_seen));

	// Clock of 100 ns.
	always #50 clock = ~clock;

	// Send bytes come from a counter so that each read byte is distinct.
	assign tx_data = {tx_idx, ~tx_idx};

	// Wire watch: bits at each clock rise, event counts and received bytes.
	always @(posedge clock) begin
		scl_q <= bus.scl;
		if (bus.scl && !scl_q) wire_bits <= {wire_bits[7:0], bus.sda};
		if (start_seen === 1'b1) n_start <= n_start + 1;
		if (stop_seen === 1'b1) n_stop <= n_stop + 1;
		if (collision === 1'b1) n_coll <= n_coll + 1;
		if (rx_valid === 1'b1 && rx_ready) got.push_back(rx_data);
	end

	// Record each send byte as the device takes it.
	always @(negedge clock) begin
		if (tx_take === 1'b1) begin
			sent.push_back(tx_data);
			tx_idx <= tx_idx + 4'h1;
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [8:0] got_v, input logic [8:0] exp_v);
		tests_run++;
		if (got_v !== exp_v) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got_v, exp_v);
		end
	endtask

	// One host command; waits bounded for ready and for the answer.
	task automatic host_op(input i2cbf_cmd_e c, input logic [7:0] d, input logic nk);
		int k;
		k = 0;
		@(negedge clock);
		while (cmd_ready !== 1'b1 && k < 9000) begin
			@(negedge clock);
			k++;
		end
		cmd = c;
		cmd_data = d;
		cmd_nack = nk;
		cmd_valid = 1'b1;
		@(negedge clock);
		// A Start on a busy bus is held off, so the request stays up until ready drops.
		while (cmd_ready === 1'b1 && k < 9000) begin
			@(negedge clock);
			k++;
		end
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && k < 9000) begin
			@(negedge clock);
			k++;
		end
		check({8'h00, rsp_valid}, 9'h001);
	endtask

	task automatic wr(input logic [7:0] d, input logic ak);
		host_op(C_WRITE, d, 1'b0);
		check({7'h00, rsp_lost, rsp_ack}, {8'h00, ak});
		check(wire_bits, {d, ~ak});
	endtask

	task automatic rd(input logic nk);
		logic [7:0] e;
		host_op(C_READ, 8'h00, nk);
		e = sent.pop_front();
		check({rsp_data, 1'b0}, {e, 1'b0});
		check(wire_bits, {e, nk});
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog sized well above the longest expected run.
	initial begin
		repeat (60000) @(posedge clock);
		n_mismatch++;
		end_of_test();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (4) @(negedge clock);
		sys_rst = 1'b0;
		repeat (12) @(negedge clock);
		check({8'h00, bus_idle}, 9'h001);
		$display("test idle done");
		// Writes with the receive side stalled; the fifth byte must stretch the clock.
		rx_ready = 1'b0;
		host_op(C_START, 8'h00, 1'b0);
		wr({7'h5A, 1'b0}, 1'b1);
		check(9'(n_start), 9'h001);
		check({8'h00, bus_idle}, 9'h000);
		fork
			for (int i = 0; i < 5; i++) wr(wdat[i], 1'b1);
			begin
				repeat (1500) @(negedge clock);
				check({7'h00, rx_valid, bus.dev_scl_oe}, 9'h003);
				rx_ready = 1'b1;
			end
		join
		host_op(C_STOP, 8'h00, 1'b0);
		repeat (20) @(negedge clock);
		check(9'(n_stop), 9'h001);
		for (int i = 0; i < 5; i++) check({1'b0, got[got.size() - 5 + i]}, {1'b0, wdat[i]});
		$display("test write done");
		// Address that does not match gets no acknowledge.
		host_op(C_START, 8'h00, 1'b0);
		wr({7'h5B, 1'b0}, 1'b0);
		host_op(C_STOP, 8'h00, 1'b0);
		$display("test mismatch done");
		// Read with the send side late, so the device stretches after the address.
		tx_valid = 1'b0;
		fork
			begin
				repeat (400) @(negedge clock);
				tx_valid = 1'b1;
			end
		join_none
		host_op(C_START, 8'h00, 1'b0);
		wr({7'h5A, 1'b1}, 1'b1);
		rd(1'b0);
		rd(1'b0);
		rd(1'b1);
		host_op(C_STOP, 8'h00, 1'b0);
		$display("test read done");
		// Restart turns a write into a read without a stop; five starts so far, the Restart included.
		host_op(C_START, 8'h00, 1'b0);
		wr({7'h5A, 1'b0}, 1'b1);
		wr(8'h42, 1'b1);
		host_op(C_START, 8'h00, 1'b0);
		wr({7'h5A, 1'b1}, 1'b1);
		check(9'(n_start), 9'h005);
		rd(1'b1);
		host_op(C_STOP, 8'h00, 1'b0);
		$display("test restart done");
		// Ten-bit addressing with the long data hold.
		data_hold_select = 1'b1;
		addr_ten_bit = 1'b1;
		slave_address_reg = 10'h2C7;
		host_op(C_START, 8'h00, 1'b0);
		wr({5'h1E, 2'b10, 1'b0}, 1'b1);
		wr(8'hC7, 1'b1);
		host_op(C_START, 8'h00, 1'b0);
		wr({5'h1E, 2'b10, 1'b1}, 1'b1);
		rd(1'b1);
		host_op(C_STOP, 8'h00, 1'b0);
		repeat (20) @(negedge clock);
		check({n_coll[7:0], bus_idle}, 9'h001);
		check(9'(n_stop), 9'h005);
		$display("test ten-bit done");
		// A disabled port lets go of both pins and stops reporting an idle bus until enabled again.
		port_module_enable = 1'b0;
		repeat (4) @(negedge clock);
		check({6'h00, bus_idle, bus.dev_scl_oe, bus.dev_sda_oe}, 9'h000);
		port_module_enable = 1'b1;
		repeat (12) @(negedge clock);
		check({8'h00, bus_idle}, 9'h001);
		$display("test enable done");
		end_of_test();
	end
endmodule
